// ==== rtl/dsp_pkg.sv ====
// Constants and types shared by both ends of the dual serial host bus port
package dsp_pkg;
  localparam int DSP_DW = 8;
  localparam int DSP_NWR = 14;
  localparam int DSP_NRD = 7;
  localparam int DSP_IDXW = 4;
  // Write register slots holding control bits used by this port
  localparam logic [3:0] DSP_WR_PTR = 4'h0;
  localparam logic [3:0] DSP_WR_VEC = 4'h2;
  localparam logic [3:0] DSP_WR_AUTO = 4'h3;
  localparam logic [3:0] DSP_WR_EXT = 4'hd;
  localparam int DSP_AUTO_BIT = 5;
  localparam int DSP_CTSIE_BIT = 5;
  localparam int DSP_MIE_BIT = 3;
  // Read register slots
  localparam logic [3:0] DSP_RD_STAT = 4'h0;
  localparam logic [3:0] DSP_RD_VEC = 4'h2;
  localparam logic [3:0] DSP_RD_PEND = 4'h3;
  localparam logic [3:0] DSP_RD_DATA = 4'h8;
  localparam logic [7:0] DSP_VEC_RST = 8'h00;
  localparam logic [7:0] DSP_REG_RST = 8'h00;
  localparam int DSP_RST_CYC = 2;
  localparam int DSP_RECOV_NS = 40;
  localparam int DSP_CLK_NS = 10;
  localparam int DSP_RECOV_CYC = (DSP_RECOV_NS + DSP_CLK_NS - 1) / DSP_CLK_NS;
  // Host access sequencer states, Gray coded
  typedef enum logic [1:0] {
    DSP_H_IDLE = 2'b00,
    DSP_H_STRB = 2'b01,
    DSP_H_HOLD = 2'b11,
    DSP_H_RECV = 2'b10
  } dsp_hstate_t;
endpackage

// ==== rtl/dsp_bus_if.sv ====
// Bus pins between the host and the serial controller port
`timescale 1ns/1ps
`default_nettype none
interface dsp_bus_if;
  logic chip_en_n;
  logic chan_a_sel;
  logic data_sel;
  logic rd_n;
  logic wr_n;
  logic intr_acknowledge_n;
  logic address_strobe_n;
  logic [7:0] host_data_o;
  logic host_data_oe_n;
  logic [7:0] dev_data_o;
  logic dev_data_oe_n;
  logic intr_n;
  logic intr_oe_n;
  // Resolved data lines
  wire [7:0] bus_data_lines = !dev_data_oe_n ? dev_data_o : (!host_data_oe_n ? host_data_o : 8'hff);
  modport dev (input chip_en_n, chan_a_sel, data_sel, rd_n, wr_n, intr_acknowledge_n, address_strobe_n,
    input bus_data_lines, output dev_data_o, dev_data_oe_n, intr_n, intr_oe_n);
  modport host (output chip_en_n, chan_a_sel, data_sel, rd_n, wr_n, intr_acknowledge_n, address_strobe_n,
    output host_data_o, host_data_oe_n, input bus_data_lines, intr_n);
endinterface
`default_nettype wire

// ==== rtl/dsp_dev.sv ====
// Device end: decodes host bus, holds channel registers, clear-to-send logic
`timescale 1ns/1ps
`default_nettype none
module dsp_dev
  import dsp_pkg::*;
(
  input wire logic clk_i, // Master clock
  input wire logic sys_rst_i, // Synchronous reset
  dsp_bus_if.dev bus, // Host bus
  input wire logic clear_to_send_first_n, // Channel A clear to send
  input wire logic clear_to_send_second_n, // Channel B clear to send
  input wire logic priority_chain_in, // Daisy chain enable in
  input wire logic [1:0] intr_req_i, // Per channel interrupt sources
  input wire logic [15:0] rx_data_i, // Received byte per channel
  output logic [1:0] tx_enable_o, // Transmitter enables
  output logic [1:0] wr_data_stb_o, // Data register written pulse
  output logic [15:0] tx_data_o, // Written data byte per channel
  output logic [1:0] rd_data_stb_o, // Data register read pulse
  output logic bus_reset_o // Reset command pulse
);
  logic [7:0] wreg_ff [2][DSP_NWR];
  logic [7:0] nxt_wreg [2][DSP_NWR];
  logic [3:0] ptr_ff [2];
  logic [3:0] nxt_ptr [2];
  logic [1:0] cts_s_ff, nxt_cts_s, cts_chg_ff, nxt_cts_chg;
  logic ack_ff, nxt_ack, acc_ff, nxt_acc, rst_ff, nxt_rst;
  logic [7:0] rdat_ff, nxt_rdat;
  logic [15:0] txd_ff, nxt_txd;
  logic [1:0] wstb_ff, nxt_wstb, rstb_ff, nxt_rstb;
  logic sel, rd, wr, ch;
  logic [3:0] idx;
  logic vec_ok;

  // Read index: control reads use pointer, data reads use receive slot
  function automatic logic [3:0] rd_index(input logic dsel, input logic [3:0] p);
    rd_index = dsel ? DSP_RD_DATA : p;
  endfunction

  // Strobe decode
  always_comb begin
    sel = !bus.chip_en_n;
    ch = bus.chan_a_sel ? 1'b0 : 1'b1;
    rd = sel && !bus.rd_n && bus.wr_n;
    wr = sel && !bus.wr_n && bus.rd_n;
    idx = rd_index(bus.data_sel, ptr_ff[ch]);
    vec_ok = ack_ff && priority_chain_in && |intr_req_i;
  end

  // Next state of registers and flags
  always_comb begin
    nxt_wreg = wreg_ff;
    nxt_ptr = ptr_ff;
    nxt_ack = !bus.address_strobe_n ? !bus.intr_acknowledge_n : ack_ff;
    nxt_cts_s = {clear_to_send_second_n, clear_to_send_first_n};
    nxt_cts_chg = cts_chg_ff;
    nxt_rst = 1'b0;
    nxt_acc = acc_ff;
    nxt_rdat = rdat_ff;
    nxt_txd = txd_ff;
    nxt_wstb = 2'b00;
    nxt_rstb = 2'b00;
    for (int c = 0; c < 2; c++) begin
      if (nxt_cts_s[c] != cts_s_ff[c] && wreg_ff[c][DSP_WR_EXT][DSP_CTSIE_BIT]) begin
        nxt_cts_chg[c] = 1'b1;
      end
    end
    if (!bus.rd_n && !bus.wr_n) begin
      nxt_rst = 1'b1;
    end else if (!acc_ff && wr) begin
      nxt_acc = 1'b1;
      if (bus.data_sel) begin
        nxt_txd[ch*8 +: 8] = bus.bus_data_lines;
        nxt_wstb[ch] = 1'b1;
      end else if (ptr_ff[ch] == DSP_WR_PTR) begin
        nxt_ptr[ch] = bus.bus_data_lines[3:0];
        nxt_wreg[ch][DSP_WR_PTR] = bus.bus_data_lines;
      end else begin
        nxt_wreg[ch][ptr_ff[ch]] = bus.bus_data_lines;
        if (ptr_ff[ch] == DSP_WR_VEC) begin
          nxt_wreg[~ch][DSP_WR_VEC] = bus.bus_data_lines;
        end
        nxt_ptr[ch] = DSP_WR_PTR;
      end
    end else if (!acc_ff && (rd || (!bus.rd_n && bus.wr_n && vec_ok))) begin
      nxt_acc = 1'b1;
      if (ack_ff) begin
        nxt_rdat = wreg_ff[0][DSP_WR_VEC];
      end else begin
        case (idx)
          DSP_RD_STAT: nxt_rdat = {2'b00, !cts_s_ff[ch], 4'h0, cts_chg_ff[ch]};
          DSP_RD_VEC: nxt_rdat = wreg_ff[0][DSP_WR_VEC];
          DSP_RD_PEND: nxt_rdat = {6'h00, cts_chg_ff};
          DSP_RD_DATA: nxt_rdat = rx_data_i[ch*8 +: 8];
          default: nxt_rdat = wreg_ff[ch][ptr_ff[ch]];
        endcase
        if (bus.data_sel) begin
          nxt_rstb[ch] = 1'b1;
        end else if (ptr_ff[ch] == DSP_RD_STAT) begin
          nxt_cts_chg[ch] = 1'b0;
        end
        nxt_ptr[ch] = DSP_WR_PTR;
      end
    end else if (bus.chip_en_n || (bus.rd_n && bus.wr_n)) begin
      nxt_acc = 1'b0;
    end
    for (int c = 0; c < 2; c++) begin
      if (nxt_cts_s[c] != cts_s_ff[c] && wreg_ff[c][DSP_WR_EXT][DSP_CTSIE_BIT]) begin
        nxt_cts_chg[c] = 1'b1;
      end
    end
    if (rst_ff) begin
      for (int c = 0; c < 2; c++) begin
        for (int r = 0; r < DSP_NWR; r++) begin
          nxt_wreg[c][r] = DSP_REG_RST;
        end
        nxt_ptr[c] = DSP_WR_PTR;
      end
      nxt_cts_chg = 2'b00;
    end
  end

  // Register all state
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      for (int c = 0; c < 2; c++) begin
        for (int r = 0; r < DSP_NWR; r++) begin
          wreg_ff[c][r] <= DSP_REG_RST;
        end
        ptr_ff[c] <= DSP_WR_PTR;
      end
      cts_s_ff <= 2'b11;
      cts_chg_ff <= 2'b00;
      ack_ff <= 1'b0;
      acc_ff <= 1'b0;
      rst_ff <= 1'b0;
      rdat_ff <= DSP_REG_RST;
      txd_ff <= 16'h0000;
      wstb_ff <= 2'b00;
      rstb_ff <= 2'b00;
    end else begin
      wreg_ff <= nxt_wreg;
      ptr_ff <= nxt_ptr;
      cts_s_ff <= nxt_cts_s;
      cts_chg_ff <= nxt_cts_chg;
      ack_ff <= nxt_ack;
      acc_ff <= nxt_acc;
      rst_ff <= nxt_rst;
      rdat_ff <= nxt_rdat;
      txd_ff <= nxt_txd;
      wstb_ff <= nxt_wstb;
      rstb_ff <= nxt_rstb;
    end
  end

  // Pin and user outputs
  always_comb begin
    bus.dev_data_o = rdat_ff;
    bus.dev_data_oe_n = !(acc_ff && !bus.rd_n && bus.wr_n && (ack_ff ? vec_ok : sel));
    bus.intr_n = !(wreg_ff[0][DSP_WR_VEC+7][DSP_MIE_BIT] && (|cts_chg_ff || |intr_req_i));
    bus.intr_oe_n = bus.intr_n;
    for (int c = 0; c < 2; c++) begin
      tx_enable_o[c] = wreg_ff[c][DSP_WR_AUTO][DSP_AUTO_BIT] ? !cts_s_ff[c] : 1'b1;
    end
    // Byte handed on to the serial engine, which sets rate and length
    tx_data_o = txd_ff;
    wr_data_stb_o = wstb_ff;
    rd_data_stb_o = rstb_ff;
    bus_reset_o = rst_ff;
  end
endmodule // dsp_dev
`default_nettype wire

// ==== rtl/dsp_host.sv ====
// Host end: runs one bus access per command with recovery spacing
`timescale 1ns/1ps
`default_nettype none
module dsp_host
  import dsp_pkg::*;
(
  input wire logic clk_i, // Clock
  input wire logic sys_rst_i, // Synchronous reset
  dsp_bus_if.host bus, // Bus pins
  input wire logic cmd_valid_i, // Command request
  output logic cmd_ready_o, // Command taken
  input wire logic cmd_write_i, // 1 write, 0 read
  input wire logic cmd_chan_a_i, // Channel A select
  input wire logic cmd_data_i, // Data (1) or control (0)
  input wire logic cmd_ack_i, // Interrupt acknowledge read
  input wire logic cmd_reset_i, // Issue reset by both strobes
  input wire logic [7:0] cmd_wdata_i, // Write byte
  output logic [7:0] rsp_rdata_o, // Read byte
  output logic rsp_valid_o // Read byte valid pulse
);
  dsp_hstate_t st_ff, nxt_st;
  logic [7:0] wd_ff, nxt_wd, rdat_ff, nxt_rdat;
  logic [4:0] ctl_ff, nxt_ctl; // write, chan a, data, ack, reset
  logic [3:0] cnt_ff, nxt_cnt;
  logic rv_ff, nxt_rv;

  // Sequencer: setup data, strobe, hold, recovery
  always_comb begin
    nxt_st = st_ff;
    nxt_wd = wd_ff;
    nxt_rdat = rdat_ff;
    nxt_ctl = ctl_ff;
    nxt_cnt = cnt_ff;
    nxt_rv = 1'b0;
    case (st_ff)
      DSP_H_IDLE: if (cmd_valid_i) begin
        nxt_ctl = {cmd_write_i, cmd_chan_a_i, cmd_data_i, cmd_ack_i, cmd_reset_i};
        nxt_wd = cmd_wdata_i;
        nxt_st = DSP_H_STRB;
      end
      DSP_H_STRB: nxt_st = DSP_H_HOLD;
      DSP_H_HOLD: begin
        if (!ctl_ff[4]) begin
          nxt_rdat = bus.bus_data_lines;
          nxt_rv = 1'b1;
        end
        nxt_cnt = 4'(DSP_RECOV_CYC);
        nxt_st = DSP_H_RECV;
      end
      DSP_H_RECV: begin
        nxt_cnt = cnt_ff - 4'h1;
        if (cnt_ff <= 4'h1) begin
          nxt_st = DSP_H_IDLE;
        end
      end
      default: nxt_st = DSP_H_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st_ff <= DSP_H_IDLE;
      wd_ff <= 8'h00;
      rdat_ff <= 8'h00;
      ctl_ff <= 5'h00;
      cnt_ff <= 4'h0;
      rv_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      wd_ff <= nxt_wd;
      rdat_ff <= nxt_rdat;
      ctl_ff <= nxt_ctl;
      cnt_ff <= nxt_cnt;
      rv_ff <= nxt_rv;
    end
  end

  // Bus pin drive
  always_comb begin
    logic act, strobe;
    act = (st_ff == DSP_H_STRB) || (st_ff == DSP_H_HOLD);
    strobe = (st_ff == DSP_H_HOLD);
    bus.chip_en_n = !(act && !ctl_ff[1]);
    bus.chan_a_sel = ctl_ff[3];
    bus.data_sel = ctl_ff[2];
    bus.intr_acknowledge_n = !(act && ctl_ff[1]);
    bus.address_strobe_n = !(st_ff == DSP_H_STRB);
    bus.wr_n = !(strobe && (ctl_ff[4] || ctl_ff[0]));
    bus.rd_n = !(strobe && (!ctl_ff[4] || ctl_ff[0]));
    bus.host_data_o = wd_ff;
    bus.host_data_oe_n = !(act && ctl_ff[4] && !ctl_ff[0]);
    cmd_ready_o = (st_ff == DSP_H_IDLE);
    rsp_rdata_o = rdat_ff;
    rsp_valid_o = rv_ff;
  end
endmodule // dsp_host
`default_nettype wire

// ==== tb/dsp_bus_props.sv ====
// Protocol checker for the bus between the host end and the device end
`timescale 1ns/1ps
`default_nettype none
module dsp_bus_props (
  input wire logic clk_i, // Clock
  input wire logic sys_rst_i, // Synchronous reset
  input wire logic chip_en_n, // Chip select
  input wire logic chan_a_sel, // Channel select
  input wire logic data_sel, // Data or control select
  input wire logic rd_n, // Read strobe
  input wire logic wr_n, // Write strobe
  input wire logic intr_acknowledge_n, // Acknowledge cycle
  input wire logic address_strobe_n, // Address strobe
  input wire logic [7:0] host_data_o, // Host write byte
  input wire logic host_data_oe_n, // Host drive enable
  input wire logic dev_data_oe_n // Device drive enable
);
  // ****************
  // Bus checks
  // ****************
  default clocking dsp_cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);
  cs_held_a: assert property (!rd_n || !wr_n |-> !chip_en_n || !intr_acknowledge_n)
    else $error("strobe low without chip select");
  cs_first_a: assert property ($fell(rd_n) || $fell(wr_n) |->
    (!$past(chip_en_n) || !$past(intr_acknowledge_n)) && !$past(address_strobe_n))
    else $error("strobe fell without prior select");
  sel_stable_a: assert property (!rd_n || !wr_n |-> $stable(chan_a_sel) && $stable(data_sel))
    else $error("selects moved under strobe");
  wdata_setup_a: assert property (!wr_n && rd_n |-> !host_data_oe_n && !$past(host_data_oe_n) && $stable(host_data_o))
    else $error("write data not set before strobe");
  dev_drive_a: assert property (!dev_data_oe_n |-> (!chip_en_n || !intr_acknowledge_n) && !rd_n && wr_n)
    else $error("device drives outside selected read");
  no_contend_a: assert property (!dev_data_oe_n |-> host_data_oe_n)
    else $error("both ends drive data lines");
  strobe_one_a: assert property (!rd_n || !wr_n |=> rd_n && wr_n)
    else $error("strobe longer than one cycle");
  recovery_a: assert property ($rose(rd_n) || $rose(wr_n) |-> (rd_n && wr_n) [*4])
    else $error("recovery gap too short");
  write_c: cover property ($fell(wr_n) && rd_n);
  read_c: cover property ($fell(rd_n) && wr_n);
  reset_c: cover property ($fell(rd_n) && $fell(wr_n));
  ack_c: cover property (!intr_acknowledge_n && !rd_n);
endmodule // dsp_bus_props
`default_nettype wire

// ==== tb/dual_serial_host_bus_port_tb_top.sv ====
// Self-checking bench joining the host end and the device end
`timescale 1ns/1ps
`default_nettype none
module dual_serial_host_bus_port_tb_top import dsp_pkg::*; ();
  typedef struct packed {logic w; logic a; logic d; logic k; logic [7:0] wd;} dsp_row_t;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic cmd_valid_i = 1'b0, cmd_write_i = 1'b0, cmd_chan_a_i = 1'b0, cmd_data_i = 1'b0;
  logic cmd_ack_i = 1'b0, cmd_reset_i = 1'b0;
  logic [7:0] cmd_wdata_i = 8'h00;
  logic cts_a_n = 1'b0, cts_b_n = 1'b1, prio_in = 1'b1;
  logic [1:0] intr_req = 2'h1;
  logic [15:0] rx_data = 16'h5aa5;
  logic cmd_ready_o, rsp_valid_o, bus_reset_o, seen_v, seen_b;
  logic [7:0] rsp_rdata_o, seen_d;
  logic [1:0] tx_enable_o, wr_data_stb_o, rd_data_stb_o, seen_w, seen_r, mask;
  logic [15:0] tx_data_o;
  int failures = 0;
  int check_count = 0;
  dsp_row_t rows[8] = '{'{1, 1, 1, 0, 8'h3c}, '{1, 0, 1, 0, 8'hc3}, '{1, 1, 1, 0, 8'hff}, '{1, 0, 1, 0, 8'h00},
    '{0, 1, 1, 0, 8'h00}, '{0, 0, 1, 0, 8'h00}, '{1, 0, 0, 0, 8'h00}, '{0, 1, 0, 1, 8'h00}};
  dsp_bus_if dsp_bus_if_i ();
  dsp_host dsp_host_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus(dsp_bus_if_i), .cmd_valid_i(cmd_valid_i),
    .cmd_ready_o(cmd_ready_o), .cmd_write_i(cmd_write_i), .cmd_chan_a_i(cmd_chan_a_i), .cmd_data_i(cmd_data_i),
    .cmd_ack_i(cmd_ack_i), .cmd_reset_i(cmd_reset_i), .cmd_wdata_i(cmd_wdata_i), .rsp_rdata_o(rsp_rdata_o),
    .rsp_valid_o(rsp_valid_o));
  dsp_dev dsp_dev_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus(dsp_bus_if_i), .clear_to_send_first_n(cts_a_n),
    .clear_to_send_second_n(cts_b_n), .priority_chain_in(prio_in), .intr_req_i(intr_req), .rx_data_i(rx_data),
    .tx_enable_o(tx_enable_o), .wr_data_stb_o(wr_data_stb_o), .tx_data_o(tx_data_o),
    .rd_data_stb_o(rd_data_stb_o), .bus_reset_o(bus_reset_o));
  dsp_bus_props dsp_bus_props_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .chip_en_n(dsp_bus_if_i.chip_en_n),
    .chan_a_sel(dsp_bus_if_i.chan_a_sel), .data_sel(dsp_bus_if_i.data_sel), .rd_n(dsp_bus_if_i.rd_n),
    .wr_n(dsp_bus_if_i.wr_n), .intr_acknowledge_n(dsp_bus_if_i.intr_acknowledge_n),
    .address_strobe_n(dsp_bus_if_i.address_strobe_n), .host_data_o(dsp_bus_if_i.host_data_o),
    .host_data_oe_n(dsp_bus_if_i.host_data_oe_n), .dev_data_oe_n(dsp_bus_if_i.dev_data_oe_n));
  // ****************
  // Clock and helper tasks
  // ****************
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t %s: saw %h expected %h", $time, what, seen, exp);
    end
  endtask
  // Print counts and verdict
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // One host command, then watch the device outputs through recovery
  task automatic run(input logic w, a, d, k, r, input logic [7:0] wd);
    {cmd_valid_i, cmd_write_i, cmd_chan_a_i, cmd_data_i, cmd_ack_i, cmd_reset_i, cmd_wdata_i} <= {1'b1, w, a, d, k, r, wd};
    repeat (12) begin
      @(negedge clk_i);
      if (cmd_ready_o === 1'b1) break;
    end
    @(posedge clk_i);
    cmd_valid_i <= 1'b0;
    {seen_w, seen_r, seen_v, seen_b} = 6'h00;
    repeat (12) begin
      @(negedge clk_i);
      {seen_w, seen_r, seen_v, seen_b} |= {wr_data_stb_o, rd_data_stb_o, rsp_valid_o, bus_reset_o};
    end
    seen_d = a ? tx_data_o[7:0] : tx_data_o[15:8];
    @(posedge clk_i);
  endtask
  // Point at slot 3 of channel A and set its auto enable
  task automatic auto_on();
    run(1, 1, 0, 0, 0, 8'h03);
    run(1, 1, 0, 0, 0, 8'h20);
  endtask
  // ****************
  // Test sequence
  // ****************
  initial begin
    repeat (20) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(negedge clk_i);
    check(tx_enable_o, 2'h3, "enables after reset");
    @(posedge clk_i);
    foreach (rows[i]) begin
      run(rows[i].w, rows[i].a, rows[i].d, rows[i].k, 1'b0, rows[i].wd);
      mask = rows[i].a ? 2'h1 : 2'h2;
      check(seen_w, (rows[i].w && rows[i].d) ? mask : 2'h0, "write strobe");
      check(seen_r, (!rows[i].w && rows[i].d) ? mask : 2'h0, "read strobe");
      check(seen_v, !rows[i].w, "read response");
      if (rows[i].w && rows[i].d) check(seen_d, rows[i].wd, "write byte");
      $display("Row %0d done", i);
    end
    cts_a_n <= 1'b1;
    auto_on();
    repeat (3) @(negedge clk_i);
    check(tx_enable_o, 2'h2, "auto enable holds A off");
    cts_a_n <= 1'b0;
    repeat (3) @(negedge clk_i);
    check(tx_enable_o, 2'h3, "auto enable lets A on");
    $display("Auto enable test done");
    @(posedge clk_i);
    cts_a_n <= 1'b1;
    run(0, 1, 1, 0, 1, 8'h00);
    check(seen_b, 1'b1, "reset command pulse");
    check({seen_w, seen_r}, 4'h0, "reset command not an access");
    check(tx_enable_o, 2'h3, "reset command clears auto enable");
    $display("Reset command test done");
    auto_on();
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(negedge clk_i);
    check(tx_enable_o, 2'h3, "enables after second reset");
    $display("Second reset test done");
    end_sim();
  end
  // Cut a hang short
  initial begin
    #40000;
    failures++;
    end_sim();
  end
endmodule // dual_serial_host_bus_port_tb_top
`default_nettype wire
